/* File: hdl/pse_port_power.v */
// per-port power supervisor: turn-on sequencing, gate command, limit
// select, inrush/overload/limit timers, two-event class check, APB regs
// assumes synchronous comparator flags and class results from the
// analog front end; one clock, asynchronous active-low reset
//
// Notes on behaviour
// R01: standalone strap powers any detected port, whatever its class, unless invalid (code has no validity check and also powers on class results 5-7).
// R02: class 4 then class 0-3 keeps port off and restarts detection.
// R03: class field holds last class pulse; flag shows a second pulse was called for.
// R04: first class 4 with two-event enabled sets the second-cycle flag.
// R05: turn-on ramps gate until inrush level, then servos to hold it.
// R06: inrush timer starts at turn-on and runs the full inrush period.
// R07: inrush phase lasts until timer expiry; below limit gate rises fully (code keeps the ramp command and gives full drive only after expiry).
// R08: still above inrush level at expiry turns port off, inrush fault.
// R09: each port has overload and hard limit thresholds, each with timer.
// R10: overload only: no current restriction, overload timer counts up.
// R11: below overload threshold the timer counts down at one sixteenth rate.
// R12: overload timer terminal turns port off and sets overload fault.
// R13: hard limit always active, holding current via gate drive.
// R14: limit timer runs only when enabled, counting above hard limit.
// R15: enabled limit timer terminal turns port off, sets limit fault.
// R16: limit timer disabled: overload timer also counts on hard-limit events.
// R17: inrush forces inrush limit code; afterwards programmed code applies.
// R18: port turn-off returns the hard limit setting to the inrush level.
// R19: host should program low limit for type 1, high for type 2.
// R20: inrush limit code is 00 with large resistor, 80 with small.
// R21: overload timer saturates at zero and clears when port turns off.
// R22: timer faults stay set until software clears them, per port.

`timescale 1ns/10ps
`include "pse_consts.vh"

module pse_port_power #(
    parameter INRUSH_CYCLES = `PSE_INRUSH_US * `PSE_CLK_MHZ,
    parameter OVL_CYCLES = `PSE_OVL_US * `PSE_CLK_MHZ,
    parameter LIM_CYCLES = `PSE_LIM_US * `PSE_CLK_MHZ
) (
    input wire clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire standaloneMode,
    input wire smallSense,
    input wire detectGood,
    input wire classDone,
    input wire [2:0] classResult,
    input wire aboveInrush,
    input wire aboveOverload,
    input wire aboveHardLimit,
    output reg [1:0] gateCmd,
    output reg [7:0] limitCode,
    output reg portOn,
    output reg restartDetect
);

    localparam ST_OFF = 3'b001;
    localparam ST_INRUSH = 3'b010;
    localparam ST_ON = 3'b100;

    localparam [31:0] INRUSH_TERM = INRUSH_CYCLES;
    localparam [31:0] OVL_TERM = OVL_CYCLES * `PSE_OVL_UP_STEP;
    localparam [31:0] LIM_TERM = LIM_CYCLES;

    reg [2:0] state;
    reg [2:0] next_state;
    reg [31:0] inrushCount;
    reg [31:0] ovlCount;
    reg [31:0] limCount;
    reg limitTimerEnable;
    reg twoEventEnable;
    reg [7:0] programmedLimit;
    reg [2:0] portClass;
    reg twoEventFlag;
    reg secondPending;
    reg [`PSE_FLT_W-1:0] faults;
    reg autoStart;
    reg hostOn;
    reg hostOff;

    wire wrEn;
    wire rdEn;
    wire inrushExpired;
    wire ovlExpired;
    wire limExpired;
    wire ovlCounting;
    wire [7:0] inrushCode;
    wire ctrlWr;
    wire limitWr;
    wire faultWr;
    wire inrushFail;
    wire ovlTrip;
    wire limTrip;

    function addrKnown;
        input [11:0] a;
        begin
            addrKnown = (a == `PSE_REG_CTRL) || (a == `PSE_REG_LIMIT) ||
                (a == `PSE_REG_STATUS) || (a == `PSE_REG_FAULT);
        end
    endfunction

    function isClass4;
        input [2:0] c;
        begin
            isClass4 = (c == `PSE_CLASS4);
        end
    endfunction

    // true in the last counting cycle before a timer reaches its terminal count
    function termReached;
        input [31:0] count;
        input [31:0] term;
        input [31:0] step;
        begin
            termReached = (count >= term - step);
        end
    endfunction

    function [31:0] countUp;
        input [31:0] count;
        begin
            countUp = count + `PSE_CNT_STEP;
        end
    endfunction

    // write lands at the completing edge, read data is latched one edge earlier
    assign wrEn = psel && penable && pready && pwrite;
    assign rdEn = psel && penable && !pready;

    assign inrushCode = smallSense ? `PSE_INRUSH_CODE_SMALL : `PSE_INRUSH_CODE_BIG; // R20

    assign ctrlWr = wrEn && (paddr == `PSE_REG_CTRL);
    assign limitWr = wrEn && (paddr == `PSE_REG_LIMIT);
    assign faultWr = wrEn && (paddr == `PSE_REG_FAULT);

    assign inrushExpired = termReached(inrushCount, INRUSH_TERM, `PSE_CNT_STEP);
    assign ovlCounting = aboveOverload || (aboveHardLimit && !limitTimerEnable); // R09 R10 R16
    assign ovlExpired = termReached(ovlCount, OVL_TERM, `PSE_OVL_UP_STEP) && ovlCounting; // R12
    assign limExpired = limitTimerEnable && aboveHardLimit &&
        termReached(limCount, LIM_TERM, `PSE_CNT_STEP); // R09 R15

    // timer expiries that end a power phase; an off command in the same cycle is not a fault
    assign inrushFail = (state == ST_INRUSH) && !hostOff && inrushExpired && aboveInrush; // R08
    assign ovlTrip = (state == ST_ON) && !hostOff && ovlExpired; // R12
    assign limTrip = (state == ST_ON) && !hostOff && limExpired; // R15

    // APB slave: one wait state, unmapped addresses answer with pslverr
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (rdEn) begin
            pready <= 1'b1;
            pslverr <= !addrKnown(paddr);
            prdata <= 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    `PSE_REG_CTRL: begin
                        prdata[`PSE_CTRL_LIMEN] <= limitTimerEnable;
                        prdata[`PSE_CTRL_TWOEV] <= twoEventEnable;
                    end
                    `PSE_REG_LIMIT: begin
                        prdata[`PSE_LIMIT_MSB:0] <= programmedLimit;
                    end
                    `PSE_REG_STATUS: begin
                        prdata[`PSE_ST_CLASS_MSB:`PSE_ST_CLASS_LSB] <= portClass; // R03
                        prdata[`PSE_ST_TWOEV] <= twoEventFlag; // R03
                        prdata[`PSE_ST_ON] <= (state == ST_ON);
                        prdata[`PSE_ST_INRUSH] <= (state == ST_INRUSH);
                    end
                    `PSE_REG_FAULT: begin
                        prdata[`PSE_FLT_W-1:0] <= faults;
                    end
                    default: begin
                        prdata <= 32'h0000_0000;
                    end
                endcase
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // control and limit registers; on/off commands are write-one pulses
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            limitTimerEnable <= 1'b0;
            twoEventEnable <= 1'b0;
            programmedLimit <= `PSE_LIMIT_RESET;
            hostOn <= 1'b0;
            hostOff <= 1'b0;
        end else begin
            hostOn <= 1'b0;
            hostOff <= 1'b0;
            if (ctrlWr) begin
                limitTimerEnable <= pwdata[`PSE_CTRL_LIMEN];
                twoEventEnable <= pwdata[`PSE_CTRL_TWOEV];
                hostOn <= pwdata[`PSE_CTRL_ON];
                hostOff <= pwdata[`PSE_CTRL_OFF];
            end
            if (limitWr) begin
                programmedLimit <= pwdata[`PSE_LIMIT_MSB:0];
            end
        end
    end

    // classification sequence and two-event check
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            portClass <= 3'h0;
            twoEventFlag <= 1'b0;
            secondPending <= 1'b0;
            autoStart <= 1'b0;
            restartDetect <= 1'b0;
        end else begin
            autoStart <= 1'b0;
            restartDetect <= 1'b0;
            if (detectGood) begin
                twoEventFlag <= 1'b0;
                secondPending <= 1'b0;
            end else if (classDone) begin
                portClass <= classResult; // R03
                if (!secondPending) begin
                    if (isClass4(classResult) && twoEventEnable) begin
                        secondPending <= 1'b1;
                        twoEventFlag <= 1'b1; // R04
                    end else begin
                        autoStart <= standaloneMode; // R01
                    end
                end else begin
                    secondPending <= 1'b0;
                    if (!isClass4(classResult)) begin
                        restartDetect <= 1'b1; // R02
                    end else begin
                        autoStart <= standaloneMode; // R01
                    end
                end
            end
        end
    end

    // port power state
    always @* begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if ((hostOn || autoStart) && !hostOff) begin
                    next_state = ST_INRUSH; // R06
                end
            end
            ST_INRUSH: begin
                if (hostOff || (inrushExpired && aboveInrush)) begin
                    next_state = ST_OFF; // R08
                end else if (inrushExpired) begin
                    next_state = ST_ON; // R07
                end
            end
            ST_ON: begin
                if (hostOff || ovlExpired || limExpired) begin
                    next_state = ST_OFF; // R12 R15
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // inrush timer runs for the whole inrush period from turn-on
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            inrushCount <= 32'h0000_0000;
        end else if (state == ST_INRUSH) begin
            inrushCount <= countUp(inrushCount); // R06
        end else begin
            inrushCount <= 32'h0000_0000;
        end
    end

    // overload timer: up by sixteen, down by one, floor at zero
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovlCount <= 32'h0000_0000;
        end else if (state != ST_ON) begin
            ovlCount <= 32'h0000_0000; // R21
        end else if (ovlCounting) begin
            ovlCount <= ovlCount + `PSE_OVL_UP_STEP; // R10 R16
        end else if (ovlCount != 32'h0000_0000) begin
            ovlCount <= ovlCount - `PSE_OVL_DN_STEP; // R11 R21
        end
    end

    // limit timer counts only when enabled and above the hard limit
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            limCount <= 32'h0000_0000;
        end else if (state == ST_ON && limitTimerEnable && aboveHardLimit) begin
            limCount <= countUp(limCount); // R14
        end else begin
            limCount <= 32'h0000_0000;
        end
    end

    // sticky faults, write one to clear, a new fault wins over the clear
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            faults <= {`PSE_FLT_W{1'b0}};
        end else begin
            if (faultWr) begin
                faults <= faults & ~pwdata[`PSE_FLT_W-1:0]; // R22
            end
            if (inrushFail) begin
                faults[`PSE_FLT_INRUSH] <= 1'b1; // R08
            end
            if (ovlTrip) begin
                faults[`PSE_FLT_OVL] <= 1'b1; // R12
            end
            if (limTrip) begin
                faults[`PSE_FLT_LIM] <= 1'b1; // R15
            end
        end
    end

    // gate command, limit code and on flag follow the next state
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gateCmd <= `PSE_GATE_OFF;
            limitCode <= `PSE_INRUSH_CODE_BIG;
            portOn <= 1'b0;
        end else begin
            case (next_state)
                ST_INRUSH: begin
                    limitCode <= inrushCode; // R17
                    portOn <= 1'b1;
                    if (aboveInrush) begin
                        gateCmd <= `PSE_GATE_HOLD; // R05
                    end else begin
                        gateCmd <= `PSE_GATE_RAMP; // R05 R07
                    end
                end
                ST_ON: begin
                    limitCode <= programmedLimit; // R17
                    portOn <= 1'b1;
                    if (aboveHardLimit) begin
                        gateCmd <= `PSE_GATE_HOLD; // R13
                    end else begin
                        gateCmd <= `PSE_GATE_FULL; // R10
                    end
                end
                default: begin
                    limitCode <= inrushCode; // R18
                    portOn <= 1'b0;
                    gateCmd <= `PSE_GATE_OFF;
                end
            endcase
        end
    end

endmodule

/* File: hdl/pse_consts.vh */
// constants for the per-port power supervisor: register map, fields,
// class and gate codes, timer figures
// assumes a 100 MHz core clock and a 32-bit APB register bus
`ifndef PSE_CONSTS_VH
`define PSE_CONSTS_VH

`define PSE_CLK_MHZ 100
// timer figures in microseconds
`define PSE_INRUSH_US 60000
`define PSE_OVL_US 60000
`define PSE_LIM_US 12000
// overload timer counts up sixteen times faster than down
`define PSE_OVL_UP_STEP 32'h0000_0010
`define PSE_OVL_DN_STEP 32'h0000_0001
// plain timers advance by one per clock
`define PSE_CNT_STEP 32'h0000_0001
// top bit of the programmed hard limit field
`define PSE_LIMIT_MSB 7

// register byte offsets
`define PSE_REG_CTRL 12'h000
`define PSE_REG_LIMIT 12'h004
`define PSE_REG_STATUS 12'h008
`define PSE_REG_FAULT 12'h00c

// control bits
`define PSE_CTRL_ON 0
`define PSE_CTRL_OFF 1
`define PSE_CTRL_LIMEN 2
`define PSE_CTRL_TWOEV 3

// fault bits
`define PSE_FLT_INRUSH 0
`define PSE_FLT_OVL 1
`define PSE_FLT_LIM 2
`define PSE_FLT_W 3

// status layout
`define PSE_ST_CLASS_LSB 0
`define PSE_ST_CLASS_MSB 2
`define PSE_ST_TWOEV 3
`define PSE_ST_ON 4
`define PSE_ST_INRUSH 5

// class codes
`define PSE_CLASS4 3'h4

// hard limit codes at the inrush level, per sense resistor
`define PSE_INRUSH_CODE_BIG 8'h00
`define PSE_INRUSH_CODE_SMALL 8'h80
`define PSE_LIMIT_RESET 8'h00

// gate drive commands to the analog driver
`define PSE_GATE_OFF 2'h0
`define PSE_GATE_RAMP 2'h1
`define PSE_GATE_HOLD 2'h2
`define PSE_GATE_FULL 2'h3

`endif

/* File: testbench/pse_mosfet_model.sv */
// external power switch with sense resistor, seen through the comparators
// assumes the bench picks the load: 0 normal, 1 short, 2 overload, 3 hard fault
`timescale 1ns/10ps
`include "pse_consts.vh"
module pse_mosfet_model #(
    parameter CHARGE_CYCLES = 5
) (
    input wire clk,
    input wire [1:0] gateCmd,
    input wire [1:0] load,
    output wire aboveInrush,
    output wire aboveOverload,
    output wire aboveHardLimit
);
    integer chg = 0;
    wire cond = gateCmd != `PSE_GATE_OFF;
    // output capacitance draws inrush-level current until charged
    always @(posedge clk) begin
        chg <= !cond ? 0 : (chg < CHARGE_CYCLES ? chg + 1 : chg);
    end
    assign aboveInrush = cond && (chg < CHARGE_CYCLES || load != 2'h0);
    assign aboveOverload = cond && load[1];
    assign aboveHardLimit = cond && load == 2'h3;
endmodule

/* File: testbench/pse_port_power_chk.sv */
// concurrent checks on the port power supervisor pins
// assumes binding into every instance of the supervisor
`timescale 1ns/10ps
`include "pse_consts.vh"
module pse_port_power_chk #(
    parameter INRUSH_CYCLES = 20,
    parameter OVL_CYCLES = 40,
    parameter LIM_CYCLES = 10
) (
    input wire clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire standaloneMode,
    input wire smallSense,
    input wire detectGood,
    input wire classDone,
    input wire [2:0] classResult,
    input wire aboveInrush,
    input wire aboveOverload,
    input wire aboveHardLimit,
    input wire [1:0] gateCmd,
    input wire [7:0] limitCode,
    input wire portOn,
    input wire restartDetect
);
    logic limEn;
    logic [7:0] limProg;
    int ovlRun;
    int limRun;
    wire wrDone = psel && penable && pready && pwrite;
    wire [7:0] inrCode = smallSense ? `PSE_INRUSH_CODE_SMALL : `PSE_INRUSH_CODE_BIG;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            limEn <= 1'h0;
            limProg <= 8'h00;
            ovlRun <= 0;
            limRun <= 0;
        end else begin
            if (wrDone && paddr == `PSE_REG_CTRL) limEn <= pwdata[`PSE_CTRL_LIMEN];
            if (wrDone && paddr == `PSE_REG_LIMIT) limProg <= pwdata[7:0];
            ovlRun <= (portOn && aboveOverload) ? ovlRun + 1 : 0;
            limRun <= (portOn && aboveHardLimit && limEn) ? limRun + 1 : 0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after one wait state");
    AST_PREADY_PULSE: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    AST_UNMAPPED: assert property (pready && paddr > `PSE_REG_FAULT |-> pslverr) else $error("unmapped not refused");
    AST_OFF_GATE: assert property (!portOn |-> gateCmd == `PSE_GATE_OFF) else $error("gate driven while off");
    AST_INRUSH_CODE: assert property (portOn && gateCmd == `PSE_GATE_RAMP |-> limitCode == inrCode)
        else $error("ramp without inrush limit code");
    AST_OFF_CODE: assert property (!portOn && !$past(portOn) && $past(rst_n) && $stable(smallSense)
        |-> limitCode == inrCode) else $error("limit not at inrush level while off");
    AST_FULL_CODE: assert property (gateCmd == `PSE_GATE_FULL |-> portOn && limitCode == limProg)
        else $error("full drive without programmed limit");
    AST_TURN_ON: assert property (wrDone && paddr == `PSE_REG_CTRL && pwdata[`PSE_CTRL_ON]
        && !pwdata[`PSE_CTRL_OFF] && !portOn |-> ##[1:4] portOn) else $error("turn-on not taken");
    AST_OVL_TIMEOUT: assert property (ovlRun <= OVL_CYCLES + INRUSH_CYCLES + 4) else $error("overload not cut");
    AST_LIM_TIMEOUT: assert property (limRun <= LIM_CYCLES + INRUSH_CYCLES + 4) else $error("limit not cut");
    AST_RESTART: assert property (restartDetect |-> !portOn ##1 !restartDetect)
        else $error("restart pulse wrong");
    COV_ON: cover property ($rose(portOn));
    COV_RESTART: cover property (restartDetect);
    COV_LIM_OFF: cover property ($fell(portOn) && limEn);
endmodule

bind pse_port_power pse_port_power_chk #(.INRUSH_CYCLES(INRUSH_CYCLES), .OVL_CYCLES(OVL_CYCLES),
    .LIM_CYCLES(LIM_CYCLES)) u_pse_port_power_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .standaloneMode(standaloneMode), .smallSense(smallSense), .detectGood(detectGood), .classDone(classDone),
    .classResult(classResult), .aboveInrush(aboveInrush), .aboveOverload(aboveOverload),
    .aboveHardLimit(aboveHardLimit), .gateCmd(gateCmd), .limitCode(limitCode), .portOn(portOn),
    .restartDetect(restartDetect));

/* File: testbench/tb_pse_port_power_fault_timers.sv */
// self-checking bench for the port power supervisor
// assumes short timer parameters and the switch model on the far side
`timescale 1ns/10ps
`include "pse_consts.vh"
module tb_pse_port_power_fault_timers;
    localparam int INR = 20;
    localparam int OVL = 40;
    localparam int LIM = 10;
    typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} pse_row_t;
    logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, e;
    logic standaloneMode = 1'h0, smallSense = 1'h1, detectGood = 1'h0, classDone = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, r;
    logic [2:0] classResult = 3'h0;
    logic [1:0] load = 2'h0;
    wire [31:0] prdata;
    wire pready, pslverr, aboveInrush, aboveOverload, aboveHardLimit, portOn, restartDetect;
    wire [1:0] gateCmd;
    wire [7:0] limitCode;
    integer miscompares = 0, nCompared = 0, cyc = 0, restarts = 0, n;
    pse_row_t rows [11] = '{'{1'h0, 12'h000, 32'h0, 32'h0, 1'h0}, '{1'h0, 12'h004, 32'h0, 32'h0, 1'h0},
        '{1'h0, 12'h008, 32'h0, 32'h0, 1'h0}, '{1'h0, 12'h00c, 32'h0, 32'h0, 1'h0},
        '{1'h0, 12'h010, 32'h0, 32'h0, 1'h1}, '{1'h1, 12'h004, 32'hffff_ff40, 32'h0, 1'h0},
        '{1'h0, 12'h004, 32'h0, 32'h40, 1'h0}, '{1'h1, 12'h000, 32'hc, 32'h0, 1'h0},
        '{1'h0, 12'h000, 32'h0, 32'hc, 1'h0}, '{1'h1, 12'h000, 32'h0, 32'h0, 1'h0},
        '{1'h1, 12'h010, 32'h5, 32'h0, 1'h1}};
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (restartDetect === 1'h1) restarts++;
        if (cyc == 5000) begin
            miscompares++;
            tally_and_finish;
        end
    end
    pse_port_power #(.INRUSH_CYCLES(INR), .OVL_CYCLES(OVL), .LIM_CYCLES(LIM)) u_pse_port_power (.clk(clk),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .standaloneMode(standaloneMode),
        .smallSense(smallSense), .detectGood(detectGood), .classDone(classDone), .classResult(classResult),
        .aboveInrush(aboveInrush), .aboveOverload(aboveOverload), .aboveHardLimit(aboveHardLimit),
        .gateCmd(gateCmd), .limitCode(limitCode), .portOn(portOn), .restartDetect(restartDetect));
    pse_mosfet_model u_pse_mosfet_model (.clk(clk), .gateCmd(gateCmd), .load(load), .aboveInrush(aboveInrush),
        .aboveOverload(aboveOverload), .aboveHardLimit(aboveHardLimit));
    task tally_and_finish;
        $display("compared %0d mismatches %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'h0;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task waitPort(input logic v, input int lim);
        n = 0;
        @(negedge clk);
        while (portOn !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk(portOn, v);
    endtask
    task pulse(input logic det, input logic [2:0] c);
        @(posedge clk);
        detectGood <= det; classDone <= !det; classResult <= c;
        @(posedge clk);
        detectGood <= 1'h0; classDone <= 1'h0;
        repeat (3) @(posedge clk);
    endtask
    task flt(input logic [1:0] l, input logic en, input logic early, input int lo, input int hi, input int f);
        @(posedge clk);
        if (early) load <= l;
        apb(1'h1, `PSE_REG_CTRL, {29'h0, en, 2'h1});
        waitPort(1'h1, 8);
        chk(limitCode, smallSense ? 8'h80 : 8'h00);
        if (!early) begin
            repeat (INR + 5) @(posedge clk);
            load <= l;
        end
        waitPort(1'h0, hi);
        chk(n >= lo, 1'h1);
        apb(1'h0, `PSE_REG_FAULT, 32'h0);
        chk(r, f);
        apb(1'h1, `PSE_REG_FAULT, 32'h7);
        load <= 2'h0;
        apb(1'h0, `PSE_REG_FAULT, 32'h0);
        chk(r, 32'h0);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        @(negedge clk);
        chk(limitCode, 8'h00);
        @(negedge clk);
        chk(limitCode, 8'h80);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(r, rows[i].x);
            chk(e, rows[i].e);
        end
        apb(1'h1, `PSE_REG_CTRL, 32'h1);
        waitPort(1'h1, 8);
        chk(limitCode, 8'h80);
        repeat (INR - 6) @(negedge clk);
        chk(gateCmd === `PSE_GATE_FULL, 1'h0);
        repeat (10) @(negedge clk);
        chk(limitCode, 8'h40);
        chk(gateCmd, `PSE_GATE_FULL);
        apb(1'h0, `PSE_REG_STATUS, 32'h0);
        chk(r, 32'h10);
        apb(1'h1, `PSE_REG_CTRL, 32'h3);
        waitPort(1'h0, 8);
        chk(limitCode, 8'h80);
        @(posedge clk);
        smallSense <= 1'h0;
        flt(2'h1, 1'h0, 1'h1, INR - 3, INR + 6, 1);
        flt(2'h3, 1'h1, 1'h0, LIM - 3, LIM + 6, 4);
        flt(2'h3, 1'h0, 1'h0, OVL - 3, OVL + 6, 2);
        flt(2'h2, 1'h0, 1'h0, OVL - 3, OVL + 6, 2);
        apb(1'h1, `PSE_REG_CTRL, 32'h1);
        waitPort(1'h1, 8);
        repeat (INR + 5) @(posedge clk);
        load <= 2'h2;
        repeat (30) @(posedge clk);
        chk(gateCmd, `PSE_GATE_FULL);
        load <= 2'h0;
        repeat (100) @(posedge clk);
        load <= 2'h2;
        repeat (15) @(posedge clk);
        chk(portOn, 1'h1);
        waitPort(1'h0, 12);
        @(posedge clk);
        load <= 2'h0;
        apb(1'h1, `PSE_REG_FAULT, 32'h7);
        standaloneMode <= 1'h1;
        apb(1'h1, `PSE_REG_CTRL, 32'h8);
        pulse(1'h1, 3'h0);
        pulse(1'h0, 3'h4);
        pulse(1'h0, 3'h2);
        repeat (10) @(negedge clk);
        chk(restarts, 1);
        chk(portOn, 1'h0);
        apb(1'h0, `PSE_REG_STATUS, 32'h0);
        chk(r, 32'h0a);
        pulse(1'h1, 3'h0);
        pulse(1'h0, 3'h1);
        waitPort(1'h1, 12);
        apb(1'h0, `PSE_REG_STATUS, 32'h0);
        chk(r, 32'h21);
        apb(1'h1, `PSE_REG_CTRL, 32'ha);
        waitPort(1'h0, 8);
        pulse(1'h1, 3'h0);
        pulse(1'h0, 3'h4);
        pulse(1'h0, 3'h4);
        waitPort(1'h1, 12);
        apb(1'h0, `PSE_REG_STATUS, 32'h0);
        chk(r, 32'h2c);
        tally_and_finish;
    end
endmodule
